// file: qpot_dev.sv
// Device end: decodes serial frames and holds wipers and stored settings.
// Assumes the link pins and straps are asynchronous to clk.
`timescale 1ns/1ps
module qpot_dev
   import qpot_pkg::*;
#(
   parameter int NV_CYC = QP_NV_WRITE_CYC
) (
   input wire logic clk,
   input wire logic reset,
   qpot_if.dev spi,
   input wire logic chip_addr_bit_hi,
   input wire logic chip_addr_bit_lo,
   output logic [31:0] wiper_position_reg,
   output logic nv_write_in_progress
);

   // ****************************************************************
   // Input synchronisers and edge detection
   // ****************************************************************
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic sck_d;
   logic cs_d;
   wire cs_n_s = sync2[4];
   wire sck_s = sync2[3];
   wire si_s = sync2[2];
   wire [1:0] addr_s = sync2[1:0];
   wire sck_rise = !cs_n_s && sck_s && !sck_d;
   wire sck_fall = !cs_n_s && !sck_s && sck_d;
   wire cs_rise = cs_n_s && !cs_d;

   always_ff @(posedge clk) begin
      sync1 <= {spi.cs_n, spi.sck, spi.si, chip_addr_bit_hi,
         chip_addr_bit_lo};
      sync2 <= sync1;
      sck_d <= sync2[3];
      cs_d <= sync2[4];
   end

   // ****************************************************************
   // Frame decode
   // ****************************************************************
   logic [4:0] cnt;
   logic [15:0] shreg;
   logic [7:0] out_sh;
   logic sending;
   logic [7:0] wpr [QP_NPOT];
   logic [7:0] stored_setting_reg [QP_NPOT][QP_NPOT];
   logic [31:0] nv_cnt;
   wire [15:0] full = {shreg[14:0], si_s};
   wire hdr_done = (cnt == QP_HDR_BITS);
   wire addr_ok = (shreg[15:8] == {QP_DEV_TYPE, 2'b00, addr_s}); // [R1]
   wire [3:0] op = shreg[7:4];
   wire [1:0] slot = shreg[3:2];
   wire [1:0] pot = shreg[1:0];
   wire stat_hit = (cnt == QP_HDR_BITS - 5'h01) &&
      (full == {QP_DEV_TYPE, 2'b00, addr_s, QP_OP_STAT, QP_STAT_TAIL});
   wire step_hit = sck_rise && hdr_done && addr_ok &&
      op == QP_OP_STEP; // [R4]
   wire exec = cs_rise && hdr_done && addr_ok;
   wire do_w2d = exec && op == QP_OP_W2D;
   wire do_gd2w = exec && op == QP_OP_GD2W && pot == 2'b00;
   wire do_gw2d = exec && op == QP_OP_GW2D && pot == 2'b00;

   always_ff @(posedge clk) begin
      if (reset || cs_n_s) begin
         cnt <= 5'h00;
         shreg <= 16'h0000;
      end else if (sck_rise && !hdr_done) begin
         cnt <= cnt + 5'h01;
         shreg <= full;
      end
   end

   // ****************************************************************
   // Status byte output
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset || cs_n_s) begin
         sending <= 1'b0;
         out_sh <= 8'h00;
         spi.so <= 1'b0;
         spi.so_oe <= 1'b0;
      end else if (sck_rise && stat_hit) begin
         sending <= 1'b1; // [R8]
         out_sh <= {7'h00, nv_write_in_progress}; // [R8]
      end else if (sck_fall && sending) begin
         spi.so <= out_sh[7]; // [R8]
         out_sh <= {out_sh[6:0], 1'b0};
         spi.so_oe <= 1'b1;
      end
   end

   // ****************************************************************
   // Wipers, stored settings and write cycle timer
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int p = 0; p < QP_NPOT; p++) begin
            wpr[p] <= 8'h00;
            for (int s = 0; s < QP_NPOT; s++) begin
               stored_setting_reg[p][s] <= 8'h00;
            end
         end
      end else begin
         if (step_hit) begin
            if (si_s && wpr[pot] != 8'hFF) begin
               wpr[pot] <= wpr[pot] + 8'h01; // [R4]
            end else if (!si_s && wpr[pot] != 8'h00) begin
               wpr[pot] <= wpr[pot] - 8'h01; // [R4]
            end
         end
         if (do_w2d) begin
            stored_setting_reg[pot][slot] <= wpr[pot]; // [R3]
         end
         for (int p = 0; p < QP_NPOT; p++) begin
            if (do_gd2w) begin
               wpr[p] <= stored_setting_reg[p][slot]; // [R6]
            end
            if (do_gw2d) begin
               stored_setting_reg[p][slot] <= wpr[p]; // [R7]
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         nv_cnt <= 32'h00000000;
         nv_write_in_progress <= 1'b0;
      end else if (do_w2d || do_gw2d) begin
         nv_cnt <= 32'(NV_CYC); // [R3] [R7]
         nv_write_in_progress <= 1'b1; // [R3] [R7]
      end else if (nv_cnt != 32'h00000000) begin
         nv_cnt <= nv_cnt - 32'h00000001;
         nv_write_in_progress <= (nv_cnt != 32'h00000001);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < QP_NPOT; gi++) begin : g_wout
         assign wiper_position_reg[8*gi +: 8] = wpr[gi];
      end
   endgenerate

endmodule

// file: qpot_host.sv
// Controller end: software orders frames over APB and the controller
// drives the serial link, generating the serial clock by a divider.
// Assumes a single 100 MHz clock and an APB master on the same clock.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Functional notes
// [R1] Frame: type id, two zeros, address bits.
// [R2] Master sends device address in first byte.
// [R3] Wiper-to-stored copy: opcode 1110, slot, pot.
// [R4] Step opcode 0010, then one direction bit per clock.
// [R5] Step bit high increments, low decrements.
// [R6] Global stored-to-wiper: opcode 0001, slot, zeros.
// [R7] Global wiper-to-stored: opcode 1000, slot, zeros.
// [R8] Status read returns seven zeros then busy flag.
module qpot_host
   import qpot_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   qpot_if.host spi
);

   // ****************************************************************
   // Header construction
   // ****************************************************************
   function automatic logic [7:0] instr_byte(input logic [2:0] cmd,
      input logic [1:0] slot, input logic [1:0] pot);
      logic [7:0] b;
      b = {QP_OP_STAT, QP_STAT_TAIL};
      case (qpot_cmd_t'(cmd))
         QP_CMD_W2D: b = {QP_OP_W2D, slot, pot}; // [R3]
         QP_CMD_STEP: b = {QP_OP_STEP, 2'b00, pot}; // [R4]
         QP_CMD_GD2W: b = {QP_OP_GD2W, slot, 2'b00}; // [R6]
         QP_CMD_GW2D: b = {QP_OP_GW2D, slot, 2'b00}; // [R7]
         default: b = {QP_OP_STAT, QP_STAT_TAIL}; // [R8]
      endcase
      return b;
   endfunction

   typedef enum logic [2:0] {
      H_IDLE, H_LEAD, H_LOW, H_HIGH, H_LAG, H_GAP
   } qpot_hst_t;

   logic [23:0] cmd_reg;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [7:0] rx;
   logic busy;
   qpot_hst_t state;
   logic [7:0] timer;
   logic [8:0] idx;
   logic [8:0] nbits;
   logic [15:0] hdr;
   logic dir;
   logic is_stat;
   logic done_p;
   logic so_s1;
   logic so_s2;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   wire setup = psel && !penable;
   wire acc = psel && penable;
   wire sel_cmd = (paddr == QP_REG_CMD);
   wire sel_stat = (paddr == QP_REG_STATUS);
   wire sel_is = (paddr == QP_REG_IRQ_STAT);
   wire sel_im = (paddr == QP_REG_IRQ_MASK);
   wire mapped = sel_cmd || sel_stat || sel_is || sel_im;
   wire wr = acc && pwrite && mapped;
   wire start = wr && sel_cmd && !busy;
   wire [2:0] c_op = pwdata[QP_CMD_OP_POS +: 3];
   wire [1:0] c_slot = pwdata[QP_CMD_SLOT_POS +: 2];
   wire [1:0] c_pot = pwdata[QP_CMD_POT_POS +: 2];
   wire [1:0] c_addr = pwdata[QP_CMD_ADDR_POS +: 2];
   wire [7:0] c_steps = pwdata[QP_CMD_STEPS_POS +: 8];
   wire c_is_step = (qpot_cmd_t'(c_op) == QP_CMD_STEP);
   wire c_is_stat = (qpot_cmd_t'(c_op) == QP_CMD_STAT);
   wire [31:0] rd_mux = sel_cmd ? {8'h00, cmd_reg} :
      sel_stat ? {22'h0, rx, rx[0], busy} :
      sel_is ? {30'h0, irq_stat} :
      sel_im ? {30'h0, irq_mask} : 32'h00000000;
   wire [1:0] ev = {done_p && is_stat && rx[0], done_p};

   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign irq = |(irq_stat & irq_mask);

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_reg <= QP_CMD_RESET;
         irq_mask <= QP_IRQ_RESET;
      end else if (wr) begin
         if (start) begin
            cmd_reg <= pwdata[23:0];
         end
         if (sel_im) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end

   // A new event wins over a clear in the same cycle.
   wire [1:0] clr = (wr && sel_is) ? pwdata[1:0] : 2'b00;

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_stat <= QP_IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~clr) | ev;
      end
   end

   // ****************************************************************
   // Serial data synchroniser
   // ****************************************************************
   always_ff @(posedge clk) begin
      so_s1 <= spi.so;
      so_s2 <= so_s1;
   end

   // ****************************************************************
   // Frame engine
   // ****************************************************************
   wire tmo = (timer == 8'h00);
   wire [8:0] idx_n = idx + 9'h001;
   wire last = (idx_n == nbits);
   wire in_hdr = (idx_n < {4'h0, QP_HDR_BITS});
   wire next_si = in_hdr ? hdr[4'hF - idx_n[3:0]] : dir; // [R5]

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= H_IDLE;
         timer <= 8'h00;
         idx <= 9'h000;
         nbits <= 9'h000;
         hdr <= 16'h0000;
         dir <= 1'b0;
         is_stat <= 1'b0;
         busy <= 1'b0;
         done_p <= 1'b0;
         rx <= 8'h00;
         spi.cs_n <= 1'b1;
         spi.sck <= 1'b0;
         spi.si <= 1'b0;
      end else begin
         done_p <= 1'b0;
         if (!tmo) begin
            timer <= timer - 8'h01;
         end
         case (state)
            H_IDLE: begin
               if (start) begin
                  hdr <= {QP_DEV_TYPE, 2'b00, c_addr,
                     instr_byte(c_op, c_slot, c_pot)}; // [R1] [R2]
                  dir <= pwdata[QP_CMD_DIR_POS]; // [R5]
                  is_stat <= c_is_stat;
                  nbits <= {4'h0, QP_HDR_BITS} +
                     (c_is_step ? {1'b0, c_steps} : 9'h000) +
                     (c_is_stat ? QP_BYTE_BITS : 9'h000); // [R4] [R8]
                  idx <= 9'h000;
                  busy <= 1'b1;
                  spi.cs_n <= 1'b0;
                  spi.si <= QP_DEV_TYPE[3];
                  timer <= 8'(QP_LEAD_CYC - 1);
                  state <= H_LEAD;
               end
            end
            H_LEAD: begin
               if (tmo) begin
                  timer <= 8'(QP_SCK_HALF_CYC - 1);
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (tmo) begin
                  spi.sck <= 1'b1;
                  timer <= 8'(QP_SCK_HALF_CYC - 1);
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tmo) begin
                  spi.sck <= 1'b0;
                  if (idx >= {4'h0, QP_HDR_BITS}) begin
                     rx <= {rx[6:0], so_s2}; // [R8]
                  end
                  idx <= idx_n;
                  if (last) begin
                     timer <= 8'(QP_LAG_CYC - 1);
                     state <= H_LAG;
                  end else begin
                     spi.si <= next_si;
                     timer <= 8'(QP_SCK_HALF_CYC - 1);
                     state <= H_LOW;
                  end
               end
            end
            H_LAG: begin
               if (tmo) begin
                  spi.cs_n <= 1'b1;
                  spi.si <= 1'b0;
                  timer <= 8'(QP_LEAD_CYC - 1);
                  state <= H_GAP;
               end
            end
            H_GAP: begin
               if (tmo) begin
                  busy <= 1'b0;
                  done_p <= 1'b1;
                  state <= H_IDLE;
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

endmodule

// file: qpot_if.sv
// Serial link between the potentiometer device and its controller.
// Assumes the testbench joins both modports; only the device drives so.
`timescale 1ns/1ps
interface qpot_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;

   modport dev (input cs_n, input sck, input si, output so, output so_oe);
   modport host (output cs_n, output sck, output si, input so,
      input so_oe);
endinterface

// file: qpot_pkg.sv
// Constants, opcodes and register map shared by both ends of the quad
// potentiometer serial link.
// Assumes a 100 MHz system clock on both ends.
package qpot_pkg;

   // ****************************************************************
   // Frame layout and opcodes
   // ****************************************************************
   localparam logic [3:0] QP_DEV_TYPE = 4'h5;
   localparam logic [3:0] QP_OP_W2D = 4'hE;
   localparam logic [3:0] QP_OP_STEP = 4'h2;
   localparam logic [3:0] QP_OP_GD2W = 4'h1;
   localparam logic [3:0] QP_OP_GW2D = 4'h8;
   localparam logic [3:0] QP_OP_STAT = 4'h5;
   localparam logic [3:0] QP_STAT_TAIL = 4'h1;
   localparam logic [4:0] QP_HDR_BITS = 5'h10;
   localparam logic [8:0] QP_BYTE_BITS = 9'h008;
   localparam int QP_NPOT = 4;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int QP_CLK_NS = 10;
   localparam int QP_SCK_PERIOD_NS = 160;
   localparam int QP_LEAD_NS = 250;
   localparam int QP_LAG_NS = 250;
   localparam int QP_SCK_HALF_CYC = QP_SCK_PERIOD_NS / 2 / QP_CLK_NS;
   localparam int QP_LEAD_CYC = (QP_LEAD_NS + QP_CLK_NS - 1) / QP_CLK_NS;
   localparam int QP_LAG_CYC = (QP_LAG_NS + QP_CLK_NS - 1) / QP_CLK_NS;
   localparam int QP_NV_WRITE_CYC = 1000;

   // ****************************************************************
   // Controller registers
   // ****************************************************************
   localparam logic [11:0] QP_REG_CMD = 12'h000;
   localparam logic [11:0] QP_REG_STATUS = 12'h004;
   localparam logic [11:0] QP_REG_IRQ_STAT = 12'h008;
   localparam logic [11:0] QP_REG_IRQ_MASK = 12'h00C;
   localparam int QP_CMD_OP_POS = 0;
   localparam int QP_CMD_SLOT_POS = 4;
   localparam int QP_CMD_POT_POS = 6;
   localparam int QP_CMD_ADDR_POS = 8;
   localparam int QP_CMD_DIR_POS = 10;
   localparam int QP_CMD_STEPS_POS = 16;
   localparam logic [23:0] QP_CMD_RESET = 24'h000000;
   localparam logic [1:0] QP_IRQ_RESET = 2'h0;

   typedef enum logic [2:0] {
      QP_CMD_W2D, QP_CMD_STEP, QP_CMD_GD2W, QP_CMD_GW2D, QP_CMD_STAT
   } qpot_cmd_t;

endpackage

// file: qpot_properties.sv
// Link checker for the quad potentiometer serial link.
// Assumes it sits beside the interface and runs on the system clock.
`timescale 1ns/1ps
module qpot_properties
   import qpot_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe
);
   // ****************************************************************
   // Frame tracking and properties
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic [8:0] bit_cnt;
   logic [15:0] hdr;
   logic sck_q;
   wire logic sck_rise = sck && !sck_q;
   wire logic stat = hdr[7:0] == {QP_OP_STAT, QP_STAT_TAIL};
   wire logic glob = hdr[7:4] == QP_OP_GD2W || hdr[7:4] == QP_OP_GW2D;

   // Counts serial clock rises in a frame and keeps the header bits.
   always_ff @(posedge clk) begin
      sck_q <= sck;
      if (reset || cs_n) begin
         bit_cnt <= 9'h000;
      end else if (sck_rise) begin
         bit_cnt <= bit_cnt + 9'h001;
      end
      if (reset) begin
         hdr <= 16'h0000;
      end else if (sck_rise && !cs_n && bit_cnt < 9'h010) begin
         hdr <= {hdr[14:0], si};
      end
   end

   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("serial clock moved outside a frame");
   a_frame_lead: assert property ($fell(cs_n) |->
      ##[25:45] $rose(sck))
      else $error("first serial clock not within lead window");
   a_dev_type_id: assert property (bit_cnt == 9'h008 |->
      hdr[7:2] == {QP_DEV_TYPE, 2'b00})
      else $error("first byte is not type id and zeros");
   a_frame_whole: assert property ($rose(cs_n) |->
      bit_cnt >= 9'h010)
      else $error("frame ended before sixteen bits");
   a_sck_high_half: assert property ($rose(sck) |->
      sck [*8] ##1 !sck)
      else $error("serial clock high phase not eight cycles");
   a_sck_low_half: assert property ($fell(sck) && !cs_n |->
      !sck [*8])
      else $error("serial clock low phase too short");
   a_si_held_high: assert property (sck && $past(sck) |->
      $stable(si))
      else $error("serial input changed while clock high");
   a_global_pot_zero: assert property (
      bit_cnt == 9'h010 && glob |-> hdr[1:0] == 2'b00)
      else $error("global transfer with nonzero pot field");
   a_status_lead_zero: assert property ($fell(sck) && stat &&
      bit_cnt > 9'h010 && bit_cnt < 9'h018 |-> so_oe && !so)
      else $error("status byte leading bit not a driven zero");
   a_so_release: assert property ($rose(cs_n) |->
      ##[0:8] !so_oe)
      else $error("serial output not released after frame");

   c_status_frame: cover property ($rose(cs_n) && stat);
   c_step_bits: cover property (bit_cnt == 9'h014 && hdr[7:4] == QP_OP_STEP);
   c_store_frame: cover property ($rose(cs_n) && hdr[7:4] == QP_OP_W2D);
endmodule

// file: quad_pot_spi_command_decoder_tb_top.sv
// Testbench joining both link ends; software drives the host over APB.
// Assumes the device straps are fixed at address 2.
`timescale 1ns/1ps
module quad_pot_spi_command_decoder_tb_top
   import qpot_pkg::*;
;
   // ****************************************************************
   // Stimulus and checks
   // ****************************************************************
   localparam logic [1:0] ADR = 2'h2;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, wipers, rd;
   logic pready, pslverr, irq, nv_busy, er;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   qpot_if link();
   qpot_host qpot_host_i(.clk(clk), .reset(reset), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .spi(link));
   qpot_dev #(.NV_CYC(600)) qpot_dev_i(.clk(clk), .reset(reset),
      .spi(link), .chip_addr_bit_hi(ADR[1]), .chip_addr_bit_lo(ADR[0]),
      .wiper_position_reg(wipers), .nv_write_in_progress(nv_busy));
   qpot_properties qpot_properties_i(.clk(clk), .reset(reset),
      .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so(link.so),
      .so_oe(link.so_oe));
   always #5 clk = ~clk;

   task automatic end_sim;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Orders one frame and polls until the controller is idle again.
   task automatic cmd(input logic [2:0] op, input logic [1:0] sl, pt,
      input logic dir, input logic [7:0] n, input logic [1:0] ad = ADR);
      apb(1'b1, QP_REG_CMD, {8'h00, n, 5'h00, dir, ad, pt, sl, 1'b0, op});
      rd = 32'h00000001;
      for (int i = 0; i < 1000 && rd[0] !== 1'b0; i++) begin
         apb(1'b0, QP_REG_STATUS, 32'h00000000);
      end
      chk("frame done", {31'h0, rd[0]}, 32'h00000000);
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 2000 && nv_busy !== 1'b0; i++) @(posedge clk);
      chk("nv busy end", {31'h0, nv_busy}, 32'h00000000);
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      chk("wipers", wipers, 32'h00000000);
      chk("nv busy", {31'h0, nv_busy}, 32'h00000000);
      cmd(QP_CMD_STEP, 2'h0, 2'h1, 1'b1, 8'h05);
      chk("step up", wipers, 32'h00000500);
      cmd(QP_CMD_STEP, 2'h0, 2'h1, 1'b0, 8'h02);
      chk("step down", wipers, 32'h00000300);
      cmd(QP_CMD_STEP, 2'h0, 2'h3, 1'b1, 8'h02);
      cmd(QP_CMD_STEP, 2'h0, 2'h0, 1'b1, 8'h04, 2'h1);
      chk("foreign addr", wipers, 32'h02000300);
      irq_is(1'b0);
      apb(1'b0, QP_REG_IRQ_STAT, 32'h00000000);
      chk("irq stat", rd, 32'h00000001);
      apb(1'b1, QP_REG_IRQ_MASK, 32'h00000003);
      irq_is(1'b1);
      apb(1'b1, QP_REG_IRQ_STAT, 32'h00000001);
      irq_is(1'b0);
      cmd(QP_CMD_W2D, 2'h2, 2'h1, 1'b0, 8'h00);
      chk("store busy", {31'h0, nv_busy}, 32'h00000001);
      cmd(QP_CMD_STAT, 2'h0, 2'h0, 1'b0, 8'h00);
      apb(1'b0, QP_REG_STATUS, 32'h00000000);
      chk("status busy", rd & 32'h000003FF, 32'h00000006);
      apb(1'b0, QP_REG_IRQ_STAT, 32'h00000000);
      chk("irq stat", rd, 32'h00000003);
      apb(1'b1, QP_REG_IRQ_STAT, 32'h00000003);
      irq_is(1'b0);
      wait_idle();
      cmd(QP_CMD_STAT, 2'h0, 2'h0, 1'b0, 8'h00);
      apb(1'b0, QP_REG_STATUS, 32'h00000000);
      chk("status idle", rd & 32'h000003FF, 32'h00000000);
      cmd(QP_CMD_STEP, 2'h0, 2'h1, 1'b1, 8'h09);
      cmd(QP_CMD_GD2W, 2'h2, 2'h0, 1'b0, 8'h00);
      chk("recall slot 2", wipers, 32'h00000300);
      chk("no store", {31'h0, nv_busy}, 32'h00000000);
      cmd(QP_CMD_STEP, 2'h0, 2'h3, 1'b1, 8'h07);
      cmd(QP_CMD_GW2D, 2'h1, 2'h0, 1'b0, 8'h00);
      chk("global busy", {31'h0, nv_busy}, 32'h00000001);
      wait_idle();
      cmd(QP_CMD_STEP, 2'h0, 2'h1, 1'b0, 8'h03);
      cmd(QP_CMD_GD2W, 2'h1, 2'h0, 1'b0, 8'h00);
      chk("recall slot 1", wipers, 32'h07000300);
      apb(1'b0, 12'h010, 32'h00000000);
      chk("unmapped err", {31'h0, er}, 32'h00000001);
      chk("unmapped data", rd, 32'h00000000);
      end_sim();
   end
endmodule
